/* File: rtl/sck_pkg.sv */
// package: constants and types for the stack check and run-control block
// ----------------------------------------------------------------------
// How it works
// - At power-on device 0 asks every connected follower for its phase before any conversion.
// - A follower phase that disagrees with the stack layout sets the power-on fault bit and keeps conversion off.
// - Once all followers have answered, device 0 sends its remaining strap settings to each of them.
// - Block payloads travel least significant byte first, in ascending order.
// - Byte N of a block value carries bits 8N+7 down to 8N.
// - Run-control lives at command code 01h, written and read as one unsigned byte.
// - Run-control is volatile only, never saved or restored, and may change at any time.
// - Conversion starts or stops from run-control together with the enable pin, as the on/off config selects.
// - Run-control also picks the margin level and whether soft-stop is used.
// - Margin codes 0-2 mean off, 5 and 6 low, 9 and 10 high, the rest invalid.
// - Soft-off 0 stops at once with the stage high-Z; soft-off 1 runs on for a delay and then ramps down.
// - An unsupported run-control write is rejected, flags status and notifies the host.
// ----------------------------------------------------------------------
package sck_pkg;
    localparam logic [7:0] CMD_RUN_CONTROL   = 8'h01;
    localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
    localparam logic [7:0] CMD_STACK         = 8'hEC;
    localparam logic [7:0] CMD_STATUS_VENDOR = 8'h80;
    localparam logic [7:0] RUN_CONTROL_RESET = 8'h00;
    localparam int         BIT_ON_OFF        = 7;
    localparam int         BIT_SOFT_OFF      = 6;
    localparam int         MARGIN_LSB        = 2;
    localparam int         BIT_POR_FAULT     = 0;
    localparam int         CFG_CMD_BIT       = 3;   // on/off config: obey run-control
    localparam int         CFG_PIN_BIT       = 2;   // on/off config: obey enable pin
    localparam int         CFG_POL_BIT       = 1;   // enable pin polarity, 1 = high
    localparam logic [7:0] ON_OFF_CFG_RESET  = 8'h1E;
    localparam int         CLK_MHZ           = 50;
    localparam int         TOFF_DELAY_US     = 1;
    localparam int         TOFF_DELAY_CYC    = TOFF_DELAY_US * CLK_MHZ;
    localparam int         QUERY_TIMEOUT_US  = 20;
    localparam int         QUERY_TIMEOUT_CYC = QUERY_TIMEOUT_US * CLK_MHZ;
    typedef enum logic [1:0] {
        MARGIN_OFF,
        MARGIN_LOW,
        MARGIN_HIGH
    } sck_margin_t;
endpackage

/* File: rtl/sck_stack_control.sv */
// module: stack power-on check, strap sharing and run-control command
`timescale 1ns/100ps
`default_nettype none
module sck_stack_control
    import sck_pkg::*;
#(
    parameter int NFOL = 3,
    parameter int STRAPW = 16
) (
    input  wire logic              clk,
    input  wire logic              srst,
    // serial management command port, one byte per strobe
    input  wire logic              cmdWrite,
    input  wire logic              cmdRead,
    input  wire logic [7:0]        cmdCode,
    input  wire logic [7:0]        cmdWdata,
    output logic      [7:0]        cmdRdata,
    output logic                   cmdRvalid,
    output logic                   cmdInvalid,
    output logic                   hostAlert,
    // stack setup
    input  wire logic [3:0]        stackLayout,
    input  wire logic [NFOL-1:0]   followerPresent,
    input  wire logic [STRAPW-1:0] strapSettings,
    input  wire logic              enablePin,
    // back channel to followers
    output logic [NFOL-1:0]        phaseQuery,
    input  wire logic [NFOL-1:0]   phaseValid,
    input  wire logic [NFOL*4-1:0] phaseData,
    output logic [NFOL-1:0]        strapSend,
    output logic [STRAPW-1:0]      strapData,
    // power stage
    output logic                   stackHold,
    output logic                   convertEnable,
    output logic                   stageHighZ,
    output logic                   rampDown,
    output sck_margin_t            marginSel,
    output logic                   marginIgnoreFault,
    output logic                   porFault
);
    // ----------------------------------------------------------------
    // power-on stack check
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_QUERY, ST_WAIT, ST_SEND, ST_READY, ST_FAULT
    } sck_state_t;
    sck_state_t state, next_state;
    logic [NFOL-1:0] answered, next_answered;
    logic [15:0]     waitCnt, next_waitCnt;
    logic            next_porFault;
    logic [NFOL-1:0] next_strapSend;
    logic [STRAPW-1:0] next_strapData;
    logic [NFOL-1:0] mismatch;

    // per-follower phase compare; a follower's phase must equal layout
    genvar g;
    generate
        for (g = 0; g < NFOL; g++) begin : gCmp
            assign mismatch[g] = phaseValid[g] && followerPresent[g]
                && (phaseData[g*4 +: 4] != stackLayout);
            assign phaseQuery[g] = (state == ST_WAIT) && followerPresent[g]
                && !answered[g];
        end
    endgenerate

    // sequence: ask, collect, share straps, release
    always_comb begin
        next_state     = state;
        next_answered  = answered;
        next_waitCnt   = waitCnt;
        next_porFault  = porFault;
        next_strapSend = '0;
        next_strapData = strapData;
        case (state)
            ST_QUERY: begin
                next_answered = '0;
                next_waitCnt  = '0;
                next_state    = ST_WAIT;
            end
            ST_WAIT: begin
                next_answered = answered | (phaseValid & followerPresent);
                next_waitCnt  = waitCnt + 16'd1;
                if (|mismatch) begin
                    next_porFault = 1'b1;
                    next_state    = ST_FAULT;
                end else if ((next_answered & followerPresent)
                             == followerPresent) begin
                    next_state = ST_SEND;
                end else if (waitCnt == 16'(QUERY_TIMEOUT_CYC - 1)) begin
                    // a silent follower is treated as a failed stack check
                    next_porFault = 1'b1;
                    next_state    = ST_FAULT;
                end
            end
            ST_SEND: begin
                next_strapData = strapSettings;
                next_strapSend = followerPresent;
                next_state     = ST_READY;
            end
            ST_READY: next_state = ST_READY;
            ST_FAULT: next_state = ST_FAULT;
            default:  next_state = ST_QUERY;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state     <= ST_QUERY;
            answered  <= '0;
            waitCnt   <= '0;
            porFault  <= 1'b0;
            strapSend <= '0;
            strapData <= '0;
        end else begin
            state     <= next_state;
            answered  <= next_answered;
            waitCnt   <= next_waitCnt;
            porFault  <= next_porFault;
            strapSend <= next_strapSend;
            strapData <= next_strapData;
        end
    end

    // members stay idle until the check has passed
    assign stackHold = (state != ST_READY);

    // ----------------------------------------------------------------
    // command registers
    // ----------------------------------------------------------------
    // run-control is volatile: reset value only, no save or restore
    logic [7:0] runCtrl, next_runCtrl;
    logic [7:0] onOffCfg, next_onOffCfg;
    logic [7:0] next_cmdRdata;
    logic       next_cmdRvalid, next_cmdInvalid;
    logic       alert, next_alert;
    logic [3:0] wrMargin;
    logic       wrOk;

    assign wrMargin = cmdWdata[MARGIN_LSB +: 4];
    always_comb begin
        case (wrMargin)
            4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'hA: wrOk = 1'b1;
            default: wrOk = 1'b0;
        endcase
        // transition and reserved bits must be written as zero
        if (cmdWdata[1:0] != 2'b00) begin
            wrOk = 1'b0;
        end
    end

    // byte command decode; one byte per access so block order is trivial
    always_comb begin
        next_runCtrl    = runCtrl;
        next_onOffCfg   = onOffCfg;
        next_cmdRdata   = cmdRdata;
        next_cmdRvalid  = 1'b0;
        next_cmdInvalid = 1'b0;
        next_alert      = alert;
        if (cmdWrite) begin
            case (cmdCode)
                CMD_RUN_CONTROL: begin
                    if (wrOk) begin
                        next_runCtrl = cmdWdata;
                    end else begin
                        next_cmdInvalid = 1'b1;
                        next_alert      = 1'b1;
                    end
                end
                CMD_ON_OFF_CONFIG: next_onOffCfg = {3'b000, cmdWdata[4:0]};
                CMD_STATUS_VENDOR: next_alert = 1'b0;
                default: begin
                    next_cmdInvalid = 1'b1;
                    next_alert      = 1'b1;
                end
            endcase
        end else if (cmdRead) begin
            next_cmdRvalid = 1'b1;
            case (cmdCode)
                CMD_RUN_CONTROL:   next_cmdRdata = runCtrl;
                CMD_ON_OFF_CONFIG: next_cmdRdata = onOffCfg;
                CMD_STATUS_VENDOR: next_cmdRdata = {7'd0, porFault};
                CMD_STACK:         next_cmdRdata = {4'd0, stackLayout};
                default:           next_cmdRdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            runCtrl    <= RUN_CONTROL_RESET;
            onOffCfg   <= ON_OFF_CFG_RESET;
            cmdRdata   <= 8'h00;
            cmdRvalid  <= 1'b0;
            cmdInvalid <= 1'b0;
            alert      <= 1'b0;
        end else begin
            runCtrl    <= next_runCtrl;
            onOffCfg   <= next_onOffCfg;
            cmdRdata   <= next_cmdRdata;
            cmdRvalid  <= next_cmdRvalid;
            cmdInvalid <= next_cmdInvalid;
            alert      <= next_alert;
        end
    end
    assign hostAlert = alert;

    // ----------------------------------------------------------------
    // conversion control
    // ----------------------------------------------------------------
    logic runReq, pinOk, cmdOk;
    assign cmdOk  = !onOffCfg[CFG_CMD_BIT] || runCtrl[BIT_ON_OFF];
    assign pinOk  = !onOffCfg[CFG_PIN_BIT]
                    || (enablePin == onOffCfg[CFG_POL_BIT]);
    assign runReq = cmdOk && pinOk && !stackHold && !porFault;

    typedef enum logic [1:0] { PW_OFF, PW_ON, PW_DELAY, PW_RAMP } sck_pw_t;
    sck_pw_t pw, next_pw;
    logic [15:0] offCnt, next_offCnt;

    // turn-off profile chosen by soft-off when run is withdrawn
    always_comb begin
        next_pw     = pw;
        next_offCnt = '0;
        case (pw)
            PW_OFF: if (runReq) next_pw = PW_ON;
            PW_ON: begin
                if (!runReq) begin
                    if (runCtrl[BIT_SOFT_OFF] && !stackHold && !porFault) begin
                        next_pw = PW_DELAY;
                    end else begin
                        next_pw = PW_OFF;
                    end
                end
            end
            PW_DELAY: begin
                next_offCnt = offCnt + 16'd1;
                if (runReq) next_pw = PW_ON;
                else if (offCnt == 16'(TOFF_DELAY_CYC - 1)) next_pw = PW_RAMP;
            end
            PW_RAMP: next_pw = runReq ? PW_ON : PW_RAMP;
            default: next_pw = PW_OFF;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pw     <= PW_OFF;
            offCnt <= '0;
        end else begin
            pw     <= next_pw;
            offCnt <= next_offCnt;
        end
    end

    assign convertEnable = (pw == PW_ON) || (pw == PW_DELAY);
    assign stageHighZ    = (pw == PW_OFF);
    assign rampDown      = (pw == PW_RAMP);

    // margin decode from the stored run-control byte
    always_comb begin
        case (runCtrl[MARGIN_LSB +: 4])
            4'h5, 4'h6: marginSel = MARGIN_LOW;
            4'h9, 4'hA: marginSel = MARGIN_HIGH;
            default:    marginSel = MARGIN_OFF;
        endcase
        marginIgnoreFault = (runCtrl[MARGIN_LSB +: 4] == 4'h5)
                         || (runCtrl[MARGIN_LSB +: 4] == 4'h9);
    end
endmodule
`default_nettype wire

/* File: testbench/sck_stack_control_sva.sv */
// checker: port properties of the stack control block
`timescale 1ns/100ps
`default_nettype none
module sck_stack_control_sva
    import sck_pkg::*;
#(
    parameter int NFOL   = 3,
    parameter int STRAPW = 16
) (
    input wire logic              clk,
    input wire logic              srst,
    input wire logic              cmdWrite,
    input wire logic              cmdRead,
    input wire logic [7:0]        cmdCode,
    input wire logic [7:0]        cmdWdata,
    input wire logic              cmdRvalid,
    input wire logic              cmdInvalid,
    input wire logic              hostAlert,
    input wire logic [STRAPW-1:0] strapSettings,
    input wire logic [NFOL-1:0]   followerPresent,
    input wire logic [NFOL-1:0]   phaseQuery,
    input wire logic [NFOL-1:0]   strapSend,
    input wire logic [STRAPW-1:0] strapData,
    input wire logic              stackHold,
    input wire logic              convertEnable,
    input wire logic              stageHighZ,
    input wire sck_margin_t       marginSel,
    input wire logic              porFault
);
    // -------------------------------------------------
    // properties, one clock domain
    // -------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    property p_por; porFault |-> !convertEnable; endproperty
    a_por: assert property (p_por) else $error("converting with fault");
    property p_hold; stackHold |-> !convertEnable; endproperty
    a_hold: assert property (p_hold) else $error("converting held");
    // every present follower is asked in the second cycle after reset
    property p_query;
        $fell(srst) |=> phaseQuery == followerPresent;
    endproperty
    a_query: assert property (p_query) else $error("query unheld");
    property p_strap;
        strapSend != '0 |-> strapData == strapSettings;
    endproperty
    a_strap: assert property (p_strap) else $error("strap data bad");
    property p_read; cmdRead && !cmdWrite |=> cmdRvalid; endproperty
    a_read: assert property (p_read) else $error("no read answer");
    property p_bad;
        cmdWrite && cmdCode == CMD_RUN_CONTROL && cmdWdata[1:0] != 2'b00
        |=> cmdInvalid && hostAlert;
    endproperty
    a_bad: assert property (p_bad) else $error("bad write kept");
    property p_high;
        cmdWrite && cmdCode == CMD_RUN_CONTROL && cmdWdata[5:0] == 6'h24
        |=> marginSel == MARGIN_HIGH;
    endproperty
    a_high: assert property (p_high) else $error("margin not high");
    property p_hiz; convertEnable |-> !stageHighZ; endproperty
    a_hiz: assert property (p_hiz) else $error("stage off running");
endmodule
`default_nettype wire

/* File: testbench/sck_follower_model.sv */
// model: stacked followers answering phase queries
`timescale 1ns/100ps
`default_nettype none
module sck_follower_model #(
    parameter int NFOL = 3,
    parameter int DLY  = 4
) (
    input wire logic             clk,
    input wire logic             srst,
    input wire logic [3:0]       phase,
    input wire logic [NFOL-1:0]  phaseQuery,
    output logic     [NFOL-1:0]  phaseValid,
    output logic     [NFOL*4-1:0] phaseData,
    input wire logic [NFOL-1:0]  strapSend,
    output logic     [NFOL-1:0]  strapGot
);
    int cnt [NFOL];
    // later followers answer more slowly; data toggles when not valid
    always_ff @(posedge clk) begin
        for (int i = 0; i < NFOL; i++) begin
            phaseValid[i] <= 1'b0;
            phaseData[4*i+:4] <= ~phaseData[4*i+:4];
            if (srst) begin
                cnt[i] <= 0;
                strapGot[i] <= 1'b0;
                phaseData[4*i+:4] <= 4'h0;
            end else if (phaseQuery[i]) begin
                cnt[i] <= cnt[i] + 1;
                if (cnt[i] == DLY * (i + 1)) begin
                    phaseValid[i] <= 1'b1;
                    phaseData[4*i+:4] <= phase;
                end
            end
            if (!srst && strapSend[i]) strapGot[i] <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// testbench: stack check and run-control scenarios
`timescale 1ns/100ps
`default_nettype none
module tb;
    import sck_pkg::*;
    logic clk, srst, cmdWrite, cmdRead, enablePin, cmdRvalid, cmdInvalid;
    logic hostAlert, stackHold, convertEnable, stageHighZ, rampDown;
    logic marginIgnoreFault, porFault;
    logic [7:0] cmdCode, cmdWdata, cmdRdata, cur;
    logic [3:0] stackLayout;
    logic [2:0] followerPresent, phaseQuery, phaseValid, strapSend, strapGot;
    logic [11:0] phaseData;
    logic [15:0] strapSettings, strapData;
    sck_margin_t marginSel;
    int bad_count, cmp_count, n;
    sck_stack_control dut (.clk(clk), .srst(srst), .cmdWrite(cmdWrite),
        .cmdRead(cmdRead), .cmdCode(cmdCode), .cmdWdata(cmdWdata),
        .cmdRdata(cmdRdata), .cmdRvalid(cmdRvalid), .cmdInvalid(cmdInvalid),
        .hostAlert(hostAlert), .stackLayout(stackLayout),
        .followerPresent(followerPresent), .strapSettings(strapSettings),
        .enablePin(enablePin), .phaseQuery(phaseQuery),
        .phaseValid(phaseValid), .phaseData(phaseData),
        .strapSend(strapSend), .strapData(strapData), .stackHold(stackHold),
        .convertEnable(convertEnable), .stageHighZ(stageHighZ),
        .rampDown(rampDown), .marginSel(marginSel),
        .marginIgnoreFault(marginIgnoreFault), .porFault(porFault));
    sck_follower_model fol (.clk(clk), .srst(srst), .phase(4'h3),
        .phaseQuery(phaseQuery), .phaseValid(phaseValid),
        .phaseData(phaseData), .strapSend(strapSend), .strapGot(strapGot));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input string s, input logic [15:0] e, g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [7:0] c, d, input logic ei);
        @(posedge clk);
        cmdWrite <= 1'b1;
        cmdCode <= c;
        cmdWdata <= d;
        @(posedge clk);
        cmdWrite <= 1'b0;
        #1 chk("cmdInvalid", ei, cmdInvalid);
    endtask
    task automatic rd(input logic [7:0] c, e);
        @(posedge clk);
        cmdRead <= 1'b1;
        cmdCode <= c;
        @(posedge clk);
        cmdRead <= 1'b0;
        #1 chk("cmdRvalid", 1'b1, cmdRvalid);
        chk("cmdRdata", e, cmdRdata);
    endtask
    task automatic rst;
        @(posedge clk);
        srst <= 1'b1;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
    endtask
    // -------------------------------------------------
    // scenarios
    // -------------------------------------------------
    task automatic t_power;
        for (n = 0; n < 400 && stackHold !== 1'b0; n++) begin
            @(posedge clk);
            #1;
        end
        chk("stackHold", 1'b0, stackHold);
        if (stackHold !== 1'b0) conclude();
        // followers latch the straps one edge after the send pulse
        @(posedge clk);
        #1 chk("strapGot", 3'b111, strapGot);
        chk("porFault", 1'b0, porFault);
        rd(CMD_RUN_CONTROL, RUN_CONTROL_RESET);
        rd(CMD_STACK, 8'h03);
        rd(CMD_ON_OFF_CONFIG, ON_OFF_CFG_RESET);
    endtask
    task automatic t_margin;
        logic ok;
        for (int m = 0; m < 16; m++) begin
            ok = m inside {0, 1, 2, 5, 6, 9, 10};
            if (ok) cur = 8'h80 | 8'(m << 2);
            wr(CMD_RUN_CONTROL, 8'h80 | 8'(m << 2), !ok);
            rd(CMD_RUN_CONTROL, cur);
            if (ok) chk("marginSel", m < 3 ? MARGIN_OFF : m < 7 ? MARGIN_LOW
                : MARGIN_HIGH, marginSel);
            chk("marginIgnore", cur == 8'h94 || cur == 8'hA4,
                marginIgnoreFault);
        end
        wr(CMD_RUN_CONTROL, 8'h81, 1'b1);
        wr(8'h7F, 8'h00, 1'b1);
        rd(CMD_RUN_CONTROL, cur);
        chk("hostAlert", 1'b1, hostAlert);
        wr(CMD_STATUS_VENDOR, 8'h00, 1'b0);
        chk("hostAlert", 1'b0, hostAlert);
    endtask
    task automatic t_enable;
        @(posedge clk);
        enablePin <= 1'b0;
        wr(CMD_RUN_CONTROL, 8'h80, 1'b0);
        chk("convertEnable", 1'b0, convertEnable);
        @(posedge clk);
        enablePin <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("convertEnable", 1'b1, convertEnable);
        wr(CMD_RUN_CONTROL, 8'h00, 1'b0);
        // the power state follows the stored byte one edge later
        @(posedge clk);
        #1 chk("stageHighZ", 1'b1, stageHighZ);
        wr(CMD_RUN_CONTROL, 8'h80, 1'b0);
        wr(CMD_RUN_CONTROL, 8'h40, 1'b0);
        for (n = 0; n < 300 && convertEnable === 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk("softDelay", 1'b1, n >= TOFF_DELAY_CYC - 1
            && n <= TOFF_DELAY_CYC + 1);
        if (n >= 300) conclude();
        #1 chk("rampDown", 1'b1, rampDown);
        // pin-only control with active-low enable, command bit ignored
        wr(CMD_ON_OFF_CONFIG, 8'h14, 1'b0);
        chk("convertEnable", 1'b0, convertEnable);
        @(posedge clk);
        enablePin <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("convertEnable", 1'b1, convertEnable);
        rd(CMD_ON_OFF_CONFIG, 8'h14);
    endtask
    task automatic t_mismatch;
        rst();
        stackLayout <= 4'h5;
        rd(CMD_RUN_CONTROL, RUN_CONTROL_RESET);
        for (n = 0; n < 3000 && porFault !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk("porFault", 1'b1, porFault);
        if (porFault !== 1'b1) conclude();
        rd(CMD_STATUS_VENDOR, 8'h01);
        wr(CMD_RUN_CONTROL, 8'h80, 1'b0);
        chk("convertEnable", 1'b0, convertEnable);
        chk("stackHold", 1'b1, stackHold);
    endtask
    initial begin
        srst = 1'b1;
        cmdWrite = 1'b0;
        cmdRead = 1'b0;
        cmdCode = 8'h00;
        cmdWdata = 8'h00;
        enablePin = 1'b1;
        stackLayout = 4'h3;
        followerPresent = 3'b111;
        strapSettings = 16'hA5_C3;
        bad_count = 0;
        cmp_count = 0;
        cur = 8'h00;
        rst();
        t_power();
        t_margin();
        t_enable();
        t_mismatch();
        conclude();
    end
endmodule
bind sck_stack_control sck_stack_control_sva #(.NFOL(NFOL), .STRAPW(STRAPW))
    u_sva (.clk(clk), .srst(srst), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
    .cmdCode(cmdCode), .cmdWdata(cmdWdata), .cmdRvalid(cmdRvalid),
    .cmdInvalid(cmdInvalid), .hostAlert(hostAlert),
    .strapSettings(strapSettings), .followerPresent(followerPresent),
    .phaseQuery(phaseQuery),
    .strapSend(strapSend), .strapData(strapData), .stackHold(stackHold),
    .convertEnable(convertEnable), .stageHighZ(stageHighZ),
    .marginSel(marginSel), .porFault(porFault));
`default_nettype wire
